// File: pkg/two_wire_pkg.sv
// constants, register map and carrier types of the two-wire slave port
package two_wire_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_CTRL      = 10'h09d;
  localparam logic [9:0]  IDX_ADDR      = 10'h09e;
  localparam logic [9:0]  IDX_DATA      = 10'h09f;
  localparam int unsigned APB_AW        = 12;

  // control/status field positions
  localparam int unsigned CTRL_EN_BIT   = 7;
  localparam int unsigned CTRL_IRQ_BIT  = 6;
  localparam int unsigned CTRL_GCA_BIT  = 4;
  localparam int unsigned CTRL_ACK_BIT  = 3;
  localparam int unsigned CTRL_ST_LSB   = 0;
  // own-address field positions
  localparam int unsigned ADDR_OWN_LSB  = 1;
  localparam int unsigned ADDR_GC_BIT   = 0;

  // reset values
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  ADDR_RST      = 8'h00;
  localparam logic [7:0]  DATA_RST      = 8'h00;

  localparam logic [6:0]  GC_ADDRESS    = 7'h00;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // reported state codes
  localparam logic [2:0]  CODE_IDLE     = 3'h0;
  localparam logic [2:0]  CODE_ADDR     = 3'h1;
  localparam logic [2:0]  CODE_RX       = 3'h2;
  localparam logic [2:0]  CODE_TX       = 3'h3;
  localparam logic [2:0]  CODE_TXNACK   = 3'h4;
  localparam logic [2:0]  CODE_TXEND    = 3'h5;

  typedef enum logic [2:0] {
    M_IDLE,
    M_ADDR,
    M_RX,
    M_TX,
    M_TXNACK,
    M_TXEND
  } mode_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

endpackage : two_wire_pkg

// File: design/two_wire_slave_port.sv
// two-wire slave port with apb register access and embedded checks

module two_wire_slave_port (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire two_wire_pkg::apb_req_t apb_req,
  output two_wire_pkg::apb_rsp_t      apb_rsp,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe
);
  import two_wire_pkg::*;

  function automatic logic [2:0] code_of(input mode_t m);
    case (m)
      M_IDLE:   code_of = CODE_IDLE;
      M_ADDR:   code_of = CODE_ADDR;
      M_RX:     code_of = CODE_RX;
      M_TX:     code_of = CODE_TX;
      M_TXNACK: code_of = CODE_TXNACK;
      M_TXEND:  code_of = CODE_TXEND;
      default:  code_of = CODE_IDLE;
    endcase
  endfunction : code_of

  function automatic logic hit(input logic [APB_AW-1:0] a, input logic [9:0] idx);
    hit = (a[APB_AW-1:2] == idx);
  endfunction : hit

  // line synchronisers and edge history
  logic       scl_s1_q, scl_s2_q, scl_p_q;
  logic       sda_s1_q, sda_s2_q, sda_p_q;

  // register fields
  logic       port_enable_q;
  logic       port_irq_flag_q;
  logic       general_call_hit_q;
  logic       ack_enable_q;
  logic [6:0] own_slave_address_q;
  logic       general_call_enable_q;
  logic [7:0] tx_byte_q;
  logic [7:0] rx_byte_q;

  // link engine
  mode_t      mode_q;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic       ack_phase_q;
  logic       read_dir_q;
  logic       drive_q;
  logic       master_not_acknowledge_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q  <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q  <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_p_q  <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_p_q  <= sda_s2_q;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_s2_q & ~scl_p_q;
  assign scl_fall  = ~scl_s2_q & scl_p_q;
  assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_det  = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

  // bus decode
  logic wr_en, rd_sel, sel_ctrl, sel_addr, sel_data;
  assign sel_ctrl = hit(apb_req.paddr, IDX_CTRL);
  assign sel_addr = hit(apb_req.paddr, IDX_ADDR);
  assign sel_data = hit(apb_req.paddr, IDX_DATA);
  assign wr_en    = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_sel   = sel_ctrl | sel_addr | sel_data;

  // byte-level events
  logic byte_end, ack_end, addr_match, gc_match, addr_hit, rx_done, tx_done;
  logic active;
  assign active     = port_enable_q & (mode_q != M_IDLE);
  assign byte_end   = port_enable_q & scl_fall & ~ack_phase_q & (bit_cnt_q == BITS_PER_BYTE);
  assign ack_end    = port_enable_q & scl_fall & ack_phase_q;
  assign gc_match   = general_call_enable_q & (shift_q[7:1] == GC_ADDRESS)
                      & ~shift_q[0];
  assign addr_match = (shift_q[7:1] == own_slave_address_q) | gc_match;
  assign addr_hit   = byte_end & (mode_q == M_ADDR) & addr_match & ack_enable_q;
  assign rx_done    = byte_end & (mode_q == M_RX);
  assign tx_done    = byte_end & (mode_q == M_TX);

  // control register: enable and ack-enable
  always_ff @(posedge clk) begin
    if (srst) begin
      port_enable_q <= CTRL_RST[CTRL_EN_BIT];
      ack_enable_q  <= CTRL_RST[CTRL_ACK_BIT];
    end else if (wr_en && sel_ctrl) begin
      port_enable_q <= apb_req.pwdata[CTRL_EN_BIT];
      ack_enable_q  <= apb_req.pwdata[CTRL_ACK_BIT];
    end
  end

  // interrupt flag: any hardware event wins over a software clear
  logic irq_event;
  assign irq_event = addr_hit | rx_done | tx_done
                     | ((start_det | stop_det) & active & (mode_q != M_ADDR));
  always_ff @(posedge clk) begin
    if (srst) begin
      port_irq_flag_q <= CTRL_RST[CTRL_IRQ_BIT];
    end else if (irq_event) begin
      port_irq_flag_q <= 1'b1;
    end else if (wr_en && sel_ctrl && !apb_req.pwdata[CTRL_IRQ_BIT]) begin
      port_irq_flag_q <= 1'b0;
    end
  end

  // general-call flag: set on match, dropped at the next start or stop
  always_ff @(posedge clk) begin
    if (srst) begin
      general_call_hit_q <= CTRL_RST[CTRL_GCA_BIT];
    end else if (addr_hit && gc_match) begin
      general_call_hit_q <= 1'b1;
    end else if (start_det || stop_det || !port_enable_q) begin
      general_call_hit_q <= 1'b0;
    end
  end

  // own address and general-call enable
  always_ff @(posedge clk) begin
    if (srst) begin
      own_slave_address_q   <= ADDR_RST[7:ADDR_OWN_LSB];
      general_call_enable_q <= ADDR_RST[ADDR_GC_BIT];
    end else if (wr_en && sel_addr) begin
      own_slave_address_q   <= apb_req.pwdata[7:ADDR_OWN_LSB];
      general_call_enable_q <= apb_req.pwdata[ADDR_GC_BIT];
    end
  end

  // data buffer: transmit byte written by software, receive byte by hardware
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_byte_q <= DATA_RST;
    end else if (wr_en && sel_data) begin
      tx_byte_q <= apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_byte_q <= DATA_RST;
    end else if (rx_done && ack_enable_q) begin
      rx_byte_q <= shift_q;
    end
  end

  // bit counter, shifter and acknowledge phase
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_q     <= DATA_RST;
      bit_cnt_q   <= 4'h0;
      ack_phase_q <= 1'b0;
      master_not_acknowledge_q <= 1'b0;
    end else if (!port_enable_q || start_det || stop_det) begin
      bit_cnt_q   <= 4'h0;
      ack_phase_q <= 1'b0;
    end else if (scl_rise && !ack_phase_q && mode_q inside {M_ADDR, M_RX, M_TX}) begin
      shift_q   <= {shift_q[6:0], sda_s2_q};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (scl_rise && ack_phase_q) begin
      master_not_acknowledge_q <= sda_s2_q;
    end else if (byte_end) begin
      bit_cnt_q   <= 4'h0;
      ack_phase_q <= (mode_q != M_ADDR) | addr_hit;
    end else if (ack_end) begin
      ack_phase_q <= 1'b0;
      if ((mode_q == M_ADDR && read_dir_q) || (mode_q == M_TX && !master_not_acknowledge_q)) begin
        shift_q <= tx_byte_q;
      end
    end
  end

  // direction latched from the address frame
  always_ff @(posedge clk) begin
    if (srst) begin
      read_dir_q <= 1'b0;
    end else if (addr_hit) begin
      read_dir_q <= shift_q[0] & ~gc_match;
    end
  end

  // transfer state
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= M_IDLE;
    end else if (!port_enable_q) begin
      mode_q <= M_IDLE;
    end else if (stop_det) begin
      mode_q <= M_IDLE;
    end else if (start_det) begin
      mode_q <= M_ADDR;
    end else if (byte_end && mode_q == M_ADDR && !addr_hit) begin
      mode_q <= M_IDLE;
    end else if (ack_end) begin
      case (mode_q)
        M_ADDR:  mode_q <= read_dir_q ? M_TX : M_RX;
        M_RX:    mode_q <= ack_enable_q ? M_RX : M_IDLE;
        M_TX: begin
          if (master_not_acknowledge_q) begin
            mode_q <= M_TXNACK;
          end else if (!ack_enable_q) begin
            mode_q <= M_TXEND;
          end else begin
            mode_q <= M_TX;
          end
        end
        default: mode_q <= mode_q;
      endcase
    end
  end

  // data line drive: acknowledge low and transmitted zero bits only
  always_ff @(posedge clk) begin
    if (srst) begin
      drive_q <= 1'b0;
    end else if (!port_enable_q || start_det || stop_det) begin
      drive_q <= 1'b0;
    end else if (byte_end) begin
      drive_q <= addr_hit | (rx_done & ack_enable_q);
    end else if (ack_end) begin
      if (mode_q == M_ADDR && read_dir_q) begin
        drive_q <= ~tx_byte_q[7];
      end else if (mode_q == M_TX && !master_not_acknowledge_q && ack_enable_q) begin
        drive_q <= ~tx_byte_q[7];
      end else begin
        drive_q <= 1'b0;
      end
    end else if (scl_fall && mode_q == M_TX && !ack_phase_q) begin
      drive_q <= ~shift_q[7];
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = drive_q;

  // apb answer: zero wait states, error on unmapped address
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (sel_ctrl) begin
      rd_byte = {port_enable_q, port_irq_flag_q, 1'b0, general_call_hit_q,
                 ack_enable_q, code_of(mode_q)};
    end else if (sel_addr) begin
      rd_byte = {own_slave_address_q, general_call_enable_q};
    end else if (sel_data) begin
      rd_byte = rx_byte_q;
    end
  end

  assign apb_rsp.prdata  = {24'h00_0000, rd_byte};
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~rd_sel;

  // checks
  property p_disabled_idle;
    @(posedge clk) disable iff (srst)
    !port_enable_q |=> (code_of(mode_q) == CODE_IDLE) && !sda_oe;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("port acts while disabled");

  property p_stop_idle;
    @(posedge clk) disable iff (srst)
    port_enable_q && stop_det |=> code_of(mode_q) == CODE_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return to idle");

  property p_start_addr;
    @(posedge clk) disable iff (srst)
    port_enable_q && start_det |=> code_of(mode_q) == CODE_ADDR;
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("start did not enter address state");

  property p_irq_sticky;
    @(posedge clk) disable iff (srst)
    port_irq_flag_q && !(wr_en && sel_ctrl) |=> port_irq_flag_q;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("interrupt flag cleared by hardware");

  property p_addr_irq_ack;
    @(posedge clk) disable iff (srst)
    addr_hit |=> port_irq_flag_q && sda_oe && ack_phase_q;
  endproperty
  a_addr_irq_ack: assert property (p_addr_irq_ack)
    else $error("address match without flag or acknowledge");

  property p_rx_byte;
    @(posedge clk) disable iff (srst)
    rx_done && ack_enable_q |=> rx_byte_q == $past(shift_q) && port_irq_flag_q;
  endproperty
  a_rx_byte: assert property (p_rx_byte)
    else $error("received byte not stored");

  property p_nack_state;
    @(posedge clk) disable iff (srst)
    ack_end && mode_q == M_TX && master_not_acknowledge_q && !stop_det && !start_det
      |=> code_of(mode_q) == CODE_TXNACK ##1 !sda_oe;
  endproperty
  a_nack_state: assert property (p_nack_state)
    else $error("master nack did not enter state 100");

  property p_gc_flag;
    @(posedge clk) disable iff (srst)
    addr_hit && gc_match |=> general_call_hit_q && !read_dir_q;
  endproperty
  a_gc_flag: assert property (p_gc_flag)
    else $error("general call not flagged");

  property p_rx_refuse;
    @(posedge clk) disable iff (srst)
    rx_done && !ack_enable_q |=> !sda_oe;
  endproperty
  a_rx_refuse: assert property (p_rx_refuse)
    else $error("acknowledged while refusing");

endmodule : two_wire_slave_port

// File: test/tw_bus_master.sv
// behavioural two-wire bus master that drives the serial clock and start/stop
module tw_bus_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned Q = 80;  // quarter of the 320 ns serial period

  // clock stands high and data is released outside frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // every step starts clear of the system clock's rising edge
  task automatic align();
    @(negedge clk);
    #7;
  endtask : align

  // serves as a repeated start when the clock is low
  task automatic start();
    align();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask : start

  task automatic stop();
    align();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask : stop

  // data changes in mid-low and is sampled in mid-high
  task automatic xfer_bit(input logic b, output logic r);
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask : xfer_bit

  // eight bits msb first, then the ninth clock for the acknowledge
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack_out);
    align();
    for (int i = 7; i >= 0; i--) xfer_bit(tx[i], rx[i]);
    xfer_bit(ack_in, ack_out);
  endtask : xfer_byte
endmodule : tw_bus_master

// File: test/tb.sv
// self-checking bench of the two-wire slave port
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import two_wire_pkg::*;
  localparam logic [7:0] F_ST  = 8'h07;
  localparam logic [7:0] F_IRQ = 8'h40;
  localparam logic [7:0] F_GCA = 8'h10;
  localparam logic [9:0] IDX_NONE = 10'h0a0;

  logic     clk;
  logic     srst;
  apb_req_t req;
  apb_rsp_t rsp;
  logic     scl;
  logic     sda;
  logic     sda_o;
  logic     sda_oe;
  logic     m_low;
  int       err_count;
  int       n_tests;

  assign sda = (sda_oe ? sda_o : 1'b1) & ~m_low;  // pull-up on the data line

  two_wire_slave_port u_dut (
    .clk     (clk),
    .srst    (srst),
    .apb_req (req),
    .apb_rsp (rsp),
    .scl_i   (scl),
    .sda_i   (sda),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe)
  );
  tw_bus_master u_bus (.clk (clk), .sda (sda), .scl (scl), .sda_low (m_low));

  always #20 clk = ~clk;

  function automatic logic [7:0] ctrl_w(input logic en, input logic ack);
    return {en, 3'b000, ack, 3'b000};
  endfunction : ctrl_w

  function automatic logic [7:0] frame(input logic [6:0] a, input logic rw);
    return {a, rw};
  endfunction : frame

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int   n;
    n = 0;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= {idx, 2'b00};
    req.pwdata  <= {24'h00_0000, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    // answer is taken at the rising edge that samples pready high
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd  = rsp.prdata[7:0];
    err = rsp.pslverr;
    if (rsp.pready !== 1'b1) chk("pready", 8'h01, 8'h00);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    logic [7:0] d;
    logic       e;
    apb(1'b1, idx, v, d, e);
  endtask : wr

  task automatic rchk(input string name, input logic [9:0] idx, input logic [7:0] mask,
                      input logic [7:0] exp);
    logic [7:0] d;
    logic       e;
    // state code follows the pins by a few clocks through the synchronisers
    repeat (4) @(posedge clk);
    apb(1'b0, idx, 8'h00, d, e);
    chk(name, exp, d & mask);
  endtask : rchk

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  initial begin
    #2_000_000;
    err_count++;
    $display("[FAIL] watchdog expected done seen hang");
    complete_run();
  end

  initial begin
    logic [6:0] own;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] rx;
    logic       a;
    logic       e;
    clk = 1'b0;
    srst = 1'b1;
    req = '0;
    err_count = 0;
    n_tests = 0;
    void'($urandom(14));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rchk("ctrl_rst", IDX_CTRL, 8'hff, CTRL_RST);
    rchk("addr_rst", IDX_ADDR, 8'hff, ADDR_RST);
    rchk("data_rst", IDX_DATA, 8'hff, DATA_RST);
    apb(1'b1, IDX_NONE, 8'h5a, rx, e);
    chk("unmapped_wr_err", 8'h01, {7'h00, e});
    apb(1'b0, IDX_NONE, 8'h00, rx, e);
    chk("unmapped_rd", 8'h01, {7'h00, e} | rx);
    own = 7'(($urandom % 126) + 1);
    wr(IDX_ADDR, frame(own, 1'b0));
    rchk("addr_rw", IDX_ADDR, 8'hff, frame(own, 1'b0));
    wr(IDX_CTRL, ctrl_w(1'b0, 1'b1));
    u_bus.start();
    u_bus.xfer_byte(frame(own, 1'b0), 1'b1, rx, a);
    chk("disabled_nack", 8'h01, {7'h00, a});
    rchk("disabled_st", IDX_CTRL, F_ST | F_IRQ, 8'(CODE_IDLE));
    u_bus.stop();
    wr(IDX_CTRL, ctrl_w(1'b1, 1'b1));
    u_bus.start();
    rchk("start_st", IDX_CTRL, F_ST, 8'(CODE_ADDR));
    u_bus.xfer_byte(frame(own, 1'b0), 1'b1, rx, a);
    chk("addr_ack", 8'h00, {7'h00, a});
    rchk("addr_irq", IDX_CTRL, F_ST | F_IRQ, F_IRQ | CODE_RX);
    rchk("irq_held", IDX_CTRL, F_IRQ, F_IRQ);
    wr(IDX_CTRL, ctrl_w(1'b1, 1'b1));
    rchk("irq_clr", IDX_CTRL, F_IRQ, 8'h00);
    for (int i = 0; i < 3; i++) begin
      d0 = 8'($urandom);
      if (i == 0) d0 = 8'hff;
      u_bus.xfer_byte(d0, 1'b1, rx, a);
      chk("rx_ack", 8'h00, {7'h00, a});
      rchk("rx_data", IDX_DATA, 8'hff, d0);
      rchk("rx_irq", IDX_CTRL, F_ST | F_IRQ, F_IRQ | CODE_RX);
      wr(IDX_CTRL, ctrl_w(1'b1, 1'b1));
    end
    wr(IDX_CTRL, ctrl_w(1'b1, 1'b0));
    u_bus.xfer_byte(~d0, 1'b1, rx, a);
    chk("refuse_nack", 8'h01, {7'h00, a});
    rchk("refuse_st", IDX_CTRL, F_ST, 8'(CODE_IDLE));
    rchk("refuse_data", IDX_DATA, 8'hff, d0);
    u_bus.stop();
    wr(IDX_CTRL, ctrl_w(1'b1, 1'b1));
    u_bus.start();
    u_bus.xfer_byte(frame(own ^ 7'h40, 1'b0), 1'b1, rx, a);
    chk("mismatch_nack", 8'h01, {7'h00, a});
    rchk("mismatch_st", IDX_CTRL, F_ST, 8'(CODE_IDLE));
    u_bus.stop();
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    wr(IDX_DATA, d0);
    u_bus.start();
    u_bus.xfer_byte(frame(own, 1'b1), 1'b1, rx, a);
    chk("rd_addr_ack", 8'h00, {7'h00, a});
    rchk("tx_st", IDX_CTRL, F_ST, 8'(CODE_TX));
    wr(IDX_DATA, d1);
    u_bus.xfer_byte(8'hff, 1'b0, rx, a);
    chk("tx_byte0", d0, rx);
    rchk("tx_irq", IDX_CTRL, F_ST | F_IRQ, F_IRQ | CODE_TX);
    wr(IDX_CTRL, ctrl_w(1'b1, 1'b1));
    u_bus.xfer_byte(8'hff, 1'b1, rx, a);
    chk("tx_byte1", d1, rx);
    rchk("nack_st", IDX_CTRL, F_ST, 8'(CODE_TXNACK));
    wr(IDX_CTRL, ctrl_w(1'b1, 1'b1));
    u_bus.start();
    rchk("restart", IDX_CTRL, F_ST | F_IRQ, F_IRQ | CODE_ADDR);
    u_bus.xfer_byte(frame(own, 1'b1), 1'b1, rx, a);
    wr(IDX_CTRL, ctrl_w(1'b1, 1'b0));
    u_bus.xfer_byte(8'hff, 1'b0, rx, a);
    chk("txend_byte", d1, rx);
    rchk("txend_st", IDX_CTRL, F_ST, 8'(CODE_TXEND));
    wr(IDX_CTRL, ctrl_w(1'b1, 1'b1));
    u_bus.stop();
    rchk("stop_st", IDX_CTRL, F_ST | F_IRQ, F_IRQ | CODE_IDLE);
    for (int g = 0; g < 2; g++) begin
      wr(IDX_ADDR, frame(own, g[0]));
      u_bus.start();
      u_bus.xfer_byte(frame(GC_ADDRESS, 1'b0), 1'b1, rx, a);
      chk("gc_ack", {7'h00, ~g[0]}, {7'h00, a});
      rchk("gc_hit", IDX_CTRL, F_ST | F_GCA, g[0] ? (F_GCA | CODE_RX) : 8'(CODE_IDLE));
      u_bus.stop();
      rchk("gc_clr", IDX_CTRL, F_ST | F_GCA, 8'(CODE_IDLE));
    end
    complete_run();
  end
endmodule : tb
